// ---- rtl/pmu_consts.vh ----
// constants for the program / peripheral move unit
// assumes: included by bare name from every design file of the unit
`ifndef PMU_CONSTS_VH
`define PMU_CONSTS_VH

// operation codes
`define PMU_OP_PM_RD     3'h0
`define PMU_OP_PM_WR     3'h1
`define PMU_OP_PP_RD     3'h2
`define PMU_OP_PP_WR     3'h3
`define PMU_OP_PP_IMM    3'h4

// register codes
`define PMU_REG_X0       4'h0
`define PMU_REG_Y0       4'h1
`define PMU_REG_Y1       4'h2
`define PMU_REG_A        4'h3
`define PMU_REG_B        4'h4
`define PMU_REG_A1       4'h5
`define PMU_REG_B1       4'h6
`define PMU_REG_A0       4'h7
`define PMU_REG_B0       4'h8
`define PMU_REG_R0       4'h9
`define PMU_REG_R1       4'ha
`define PMU_REG_R2       4'hb
`define PMU_REG_R3       4'hc
`define PMU_REG_N        4'hd

// base cycle counts
`define PMU_PM_CYC       4'h8
`define PMU_PP_CYC       4'h2
`define PMU_PP_IMM_CYC   4'h4
`define PMU_CNT_ONE      4'h1

// addressing and data
`define PMU_PP_TOP       10'h3ff
`define PMU_SAT_POS      16'h7fff
`define PMU_SAT_NEG      16'h8000
`define PMU_ZERO16       16'h0000
`define PMU_ZERO36       36'h000000000
`define PMU_ONE16        16'h0001
`define PMU_L_BIT        6

`endif

// ---- rtl/pmu_src_sel.v ----
// source operand select with accumulator limiting
// assumes: register values come straight from the unit's register file
`timescale 1ns/1ns
`include "pmu_consts.vh"

module pmu_src_sel (
  // selection
  input  wire [3:0]  sel,
  // register values
  input  wire [15:0] x0,
  input  wire [15:0] y0,
  input  wire [15:0] y1,
  input  wire [35:0] acc_a,
  input  wire [35:0] acc_b,
  input  wire [63:0] ptrs,
  input  wire [15:0] n,
  // result
  output reg  [15:0] val,
  output reg         sat
);

  reg [35:0] acc;
  reg        full;

  always @* begin
    acc  = (sel == `PMU_REG_B) ? acc_b : acc_a;
    full = (sel == `PMU_REG_A) || (sel == `PMU_REG_B);
    sat  = full && (acc[35:32] != {4{acc[31]}});
    case (sel)
      `PMU_REG_X0: val = x0;
      `PMU_REG_Y0: val = y0;
      `PMU_REG_Y1: val = y1;
      `PMU_REG_A,
      `PMU_REG_B:  val = sat ? (acc[35] ? `PMU_SAT_NEG : `PMU_SAT_POS) : acc[31:16];
      `PMU_REG_A1: val = acc_a[31:16];
      `PMU_REG_B1: val = acc_b[31:16];
      `PMU_REG_A0: val = acc_a[15:0];
      `PMU_REG_B0: val = acc_b[15:0];
      `PMU_REG_R0: val = ptrs[15:0];
      `PMU_REG_R1: val = ptrs[31:16];
      `PMU_REG_R2: val = ptrs[47:32];
      `PMU_REG_R3: val = ptrs[63:48];
      `PMU_REG_N:  val = n;
      default:     val = `PMU_ZERO16;
    endcase
  end

endmodule // pmu_src_sel

// ---- rtl/pmu_move_unit.v ----
// execution of program memory moves and peripheral short moves
// assumes: one command at a time, memories answer with a one-cycle ack,
// the issuing side never asks for a program memory move while executing from data memory
//
// Contract
// - program memory move reads into or writes from a core register
// - full accumulator with extension in use stores the saturation constant
// - accumulator word portions as source are never limited
// - limiting sets the sticky limit flag at bit 6 until written
// - word into full accumulator is sign extended, low word zeroed
// - word into upper accumulator word leaves extension and low word alone
// - program memory read via pointer, post update by one or step, 8 cycles
// - program memory write via pointer, post update by one or step
// - program memory move takes 8 cycles plus memory wait cycles
// - peripheral address is the 6-bit short address one-extended to 16 bits
// - peripheral short move reaches exactly ffc0 through ffff
// - immediate peripheral write takes 4 cycles, register forms 2
// - peripheral short move takes its base cycles plus memory wait cycles
`timescale 1ns/1ns
`include "pmu_consts.vh"

module pmu_move_unit (
  // clock and reset
  input  wire        clock,
  input  wire        srst,
  // command
  input  wire        start,
  input  wire [2:0]  op,
  input  wire [3:0]  reg_sel,
  input  wire [1:0]  ptr_sel,
  input  wire        step_n,
  input  wire [5:0]  short_addr,
  input  wire [15:0] imm,
  // program memory
  output reg  [15:0] pm_addr,
  output reg  [15:0] pm_wdata,
  output reg         pm_rd,
  output reg         pm_wr,
  input  wire [15:0] pm_rdata,
  input  wire        pm_ack,
  // x data memory
  output reg  [15:0] xd_addr,
  output reg  [15:0] xd_wdata,
  output reg         xd_rd,
  output reg         xd_wr,
  input  wire [15:0] xd_rdata,
  input  wire        xd_ack,
  // condition code write
  input  wire        cond_code_wr,
  input  wire [7:0]  cond_code_wdata,
  // status
  output reg         busy,
  output reg         done,
  output reg         limit_flag,
  // register readback
  input  wire [3:0]  rb_sel,
  output reg  [35:0] rb_data
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_ACC  = 2'h2;

  // --------------------------------------------------------------
  // state and register file
  // --------------------------------------------------------------
  reg  [1:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [2:0]  op_q;
  reg  [3:0]  sel_q;
  reg  [1:0]  psel_q;
  reg         step_q;
  reg         sat_q;
  reg  [15:0] x0_q;
  reg  [15:0] y0_q;
  reg  [15:0] y1_q;
  reg  [35:0] a_q;
  reg  [35:0] b_q;
  reg  [15:0] n_q;
  reg  [15:0] ptr_q [0:3];

  wire [15:0] src_val;
  wire        src_sat;
  wire [63:0] ptr_flat = {ptr_q[3], ptr_q[2], ptr_q[1], ptr_q[0]};
  wire        is_pm    = (op_q == `PMU_OP_PM_RD) || (op_q == `PMU_OP_PM_WR);
  wire        is_rd    = (op_q == `PMU_OP_PM_RD) || (op_q == `PMU_OP_PP_RD);
  wire        ack      = is_pm ? pm_ack : xd_ack;
  wire        fin      = (state_q == ST_ACC) && ack;
  wire [15:0] ld_val   = is_pm ? pm_rdata : xd_rdata;
  wire        start_pm = (op == `PMU_OP_PM_RD) || (op == `PMU_OP_PM_WR);
  wire        start_wr = (op == `PMU_OP_PM_WR) || (op == `PMU_OP_PP_WR);
  reg  [3:0]  base_cyc;
  reg  [15:0] ptr_nxt;

  pmu_src_sel u_src (
    .sel   (reg_sel),
    .x0    (x0_q),
    .y0    (y0_q),
    .y1    (y1_q),
    .acc_a (a_q),
    .acc_b (b_q),
    .ptrs  (ptr_flat),
    .n     (n_q),
    .val   (src_val),
    .sat   (src_sat)
  );

  always @* begin
    if (start_pm) begin
      base_cyc = `PMU_PM_CYC;
    end else if (op == `PMU_OP_PP_IMM) begin
      base_cyc = `PMU_PP_IMM_CYC;
    end else begin
      base_cyc = `PMU_PP_CYC;
    end
    ptr_nxt = pm_addr + (step_q ? n_q : `PMU_ONE16);
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'h0;
      op_q     <= `PMU_OP_PM_RD;
      sel_q    <= `PMU_REG_X0;
      psel_q   <= 2'h0;
      step_q   <= 1'b0;
      sat_q    <= 1'b0;
      pm_addr  <= `PMU_ZERO16;
      pm_wdata <= `PMU_ZERO16;
      pm_rd    <= 1'b0;
      pm_wr    <= 1'b0;
      xd_addr  <= `PMU_ZERO16;
      xd_wdata <= `PMU_ZERO16;
      xd_rd    <= 1'b0;
      xd_wr    <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // no check: supplier keeps program moves out of data-memory execution
          if (start) begin
            state_q  <= ST_RUN;
            busy     <= 1'b1;
            cnt_q    <= base_cyc - `PMU_CNT_ONE;
            op_q     <= op;
            sel_q    <= reg_sel;
            psel_q   <= ptr_sel;
            step_q   <= step_n;
            sat_q    <= start_wr && src_sat;
            pm_addr  <= ptr_q[ptr_sel];
            pm_wdata <= src_val;
            xd_addr  <= {`PMU_PP_TOP, short_addr};
            xd_wdata <= (op == `PMU_OP_PP_IMM) ? imm : src_val;
          end
        end
        ST_RUN: begin
          if (cnt_q == `PMU_CNT_ONE) begin
            state_q <= ST_ACC;
            pm_rd   <= op_q == `PMU_OP_PM_RD;
            pm_wr   <= op_q == `PMU_OP_PM_WR;
            xd_rd   <= op_q == `PMU_OP_PP_RD;
            xd_wr   <= (op_q == `PMU_OP_PP_WR) || (op_q == `PMU_OP_PP_IMM);
          end else begin
            cnt_q <= cnt_q - `PMU_CNT_ONE;
          end
        end
        ST_ACC: begin
          if (ack) begin
            state_q <= ST_IDLE;
            pm_rd   <= 1'b0;
            pm_wr   <= 1'b0;
            xd_rd   <= 1'b0;
            xd_wr   <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // destination load
  // --------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      x0_q <= `PMU_ZERO16;
      y0_q <= `PMU_ZERO16;
      y1_q <= `PMU_ZERO16;
      a_q  <= `PMU_ZERO36;
      b_q  <= `PMU_ZERO36;
      n_q  <= `PMU_ZERO16;
    end else if (fin && is_rd) begin
      case (sel_q)
        `PMU_REG_X0: x0_q <= ld_val;
        `PMU_REG_Y0: y0_q <= ld_val;
        `PMU_REG_Y1: y1_q <= ld_val;
        `PMU_REG_A:  a_q <= {{4{ld_val[15]}}, ld_val, `PMU_ZERO16};
        `PMU_REG_B:  b_q <= {{4{ld_val[15]}}, ld_val, `PMU_ZERO16};
        `PMU_REG_A1: a_q[31:16] <= ld_val;
        `PMU_REG_B1: b_q[31:16] <= ld_val;
        `PMU_REG_A0: a_q[15:0] <= ld_val;
        `PMU_REG_B0: b_q[15:0] <= ld_val;
        `PMU_REG_N:  n_q <= ld_val;
        default: begin
        end
      endcase
    end
  end

  // pointer registers: a load into the same pointer beats its post update
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ptr
      always @(posedge clock) begin
        if (srst) begin
          ptr_q[gi] <= `PMU_ZERO16;
        end else if (fin && is_rd && ({28'h0000000, sel_q} == `PMU_REG_R0 + gi)) begin
          ptr_q[gi] <= ld_val;
        end else if (fin && is_pm && ({30'h00000000, psel_q} == gi)) begin
          ptr_q[gi] <= ptr_nxt;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // limit flag and readback
  // --------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      limit_flag <= 1'b0;
    end else begin
      // sticky, set beats a clearing write
      limit_flag <= (cond_code_wr ? cond_code_wdata[`PMU_L_BIT] : limit_flag) | (fin & sat_q);
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      rb_data <= `PMU_ZERO36;
    end else begin
      case (rb_sel)
        `PMU_REG_X0: rb_data <= {20'h00000, x0_q};
        `PMU_REG_Y0: rb_data <= {20'h00000, y0_q};
        `PMU_REG_Y1: rb_data <= {20'h00000, y1_q};
        `PMU_REG_A:  rb_data <= a_q;
        `PMU_REG_B:  rb_data <= b_q;
        `PMU_REG_R0: rb_data <= {20'h00000, ptr_q[0]};
        `PMU_REG_R1: rb_data <= {20'h00000, ptr_q[1]};
        `PMU_REG_R2: rb_data <= {20'h00000, ptr_q[2]};
        `PMU_REG_R3: rb_data <= {20'h00000, ptr_q[3]};
        `PMU_REG_N:  rb_data <= {20'h00000, n_q};
        default:     rb_data <= `PMU_ZERO36;
      endcase
    end
  end

endmodule // pmu_move_unit

// ---- bench/pmu_mem_model.sv ----
// memory model: program memory and top of x data memory, 64 words each
// assumes: strobes hold until ack; lat sets the wait cycles before ack
`timescale 1ns/1ns
module pmu_mem_model (
  // clock and wait control
  input  wire        clock,
  input  wire [1:0]  lat,
  // program memory side
  input  wire [15:0] pm_addr,
  input  wire [15:0] pm_wdata,
  input  wire        pm_rd,
  input  wire        pm_wr,
  output reg  [15:0] pm_rdata = 16'h0,
  output reg         pm_ack = 1'h0,
  // x data side
  input  wire [15:0] xd_addr,
  input  wire [15:0] xd_wdata,
  input  wire        xd_rd,
  input  wire        xd_wr,
  output reg  [15:0] xd_rdata = 16'h0,
  output reg         xd_ack = 1'h0
);
  reg [15:0] pmem [0:63];
  reg [15:0] xmem [0:63];
  reg [1:0]  pc_q = 2'h0;
  reg [1:0]  xc_q = 2'h0;

  // -------------------------
  // responders
  // -------------------------
  // idle data toggles so a stale word never passes for an answer
  always @(posedge clock) begin
    pm_ack <= 1'h0;
    pm_rdata <= ~pm_rdata;
    if ((pm_rd || pm_wr) && !pm_ack) begin
      pc_q <= (pc_q == lat) ? 2'h0 : pc_q + 2'h1;
      if (pc_q == lat) begin
        pm_ack <= 1'h1;
        pm_rdata <= pmem[pm_addr[5:0]];
        if (pm_wr) pmem[pm_addr[5:0]] <= pm_wdata;
      end
    end
  end

  always @(posedge clock) begin
    xd_ack <= 1'h0;
    xd_rdata <= ~xd_rdata;
    if ((xd_rd || xd_wr) && !xd_ack) begin
      xc_q <= (xc_q == lat) ? 2'h0 : xc_q + 2'h1;
      if (xc_q == lat) begin
        xd_ack <= 1'h1;
        xd_rdata <= xmem[xd_addr[5:0]];
        if (xd_wr) xmem[xd_addr[5:0]] <= xd_wdata;
      end
    end
  end
endmodule // pmu_mem_model

// ---- bench/pmu_move_unit_assertions.sv ----
// checker for the move unit, bound to its top module
// assumes: single clock domain, synchronous reset
`timescale 1ns/1ns
module pmu_move_chk (
  // clock and reset
  input wire        clock,
  input wire        srst,
  // command
  input wire        start,
  input wire [2:0]  op,
  input wire [5:0]  short_addr,
  input wire [15:0] imm,
  // memories
  input wire        pm_rd,
  input wire        pm_wr,
  input wire        pm_ack,
  input wire        xd_rd,
  input wire        xd_wr,
  input wire        xd_ack,
  input wire [15:0] xd_addr,
  input wire [15:0] xd_wdata,
  // status
  input wire        cond_code_wr,
  input wire [7:0]  cond_code_wdata,
  input wire        busy,
  input wire        done,
  input wire        limit_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire take = start && !busy;
  wire pms  = pm_rd || pm_wr;
  wire xds  = xd_rd || xd_wr;

  // -------------------------
  // timing
  // -------------------------
  sequence pm_wait;
    !pms [*7] ##1 pms;
  endsequence
  sequence imm_wait;
    !xds [*3] ##1 xd_wr;
  endsequence

  pm_base_a: assert property (take && op <= 3'h1 |=> pm_wait)
    else $error("program memory strobe not in cycle 8");
  pp_base_a: assert property (take && (op == 3'h2 || op == 3'h3) |=> !xds ##1 xds)
    else $error("peripheral strobe not in cycle 2");
  imm_base_a: assert property (take && op == 3'h4 |=> imm_wait)
    else $error("immediate write strobe not in cycle 4");
  imm_data_a: assert property (take && op == 3'h4 |=> xd_wdata == $past(imm))
    else $error("immediate data not on write bus");
  pp_addr_a: assert property (take && op >= 3'h2 |=> xd_addr == {10'h3ff, $past(short_addr)})
    else $error("peripheral address not one extended");
  pp_range_a: assert property (xds |-> xd_addr[15:6] == 10'h3ff)
    else $error("peripheral access outside top region");
  done_ack_a: assert property (busy && (pms && pm_ack || xds && xd_ack) |=> done && !busy)
    else $error("no completion after ack");

  // -------------------------
  // limit flag
  // -------------------------
  // sticky flag
  limit_hold_a: assert property (limit_flag && !cond_code_wr |=> limit_flag)
    else $error("limit flag dropped without a write");
  limit_rise_a: assert property ($rose(limit_flag) |->
                                 done || ($past(cond_code_wr) && $past(cond_code_wdata[6])))
    else $error("limit flag set without cause");
endmodule // pmu_move_chk

bind pmu_move_unit pmu_move_chk pmu_move_chk_i (.*);

// ---- bench/testbench.sv ----
// self-checking bench for the move unit with its memory model
// assumes: no data-execute mode exists at these ports
`timescale 1ns/1ns
`include "pmu_consts.vh"
module testbench;
  reg         clock = 1'h0;
  reg         srst = 1'h1;
  reg         start = 1'h0;
  reg  [2:0]  op = 3'h0;
  reg  [3:0]  reg_sel = 4'h0;
  reg  [1:0]  ptr_sel = 2'h0;
  reg         step_n = 1'h0;
  reg  [5:0]  short_addr = 6'h0;
  reg  [15:0] imm = 16'h0;
  reg         cond_code_wr = 1'h0;
  reg  [7:0]  cond_code_wdata = 8'h0;
  reg  [3:0]  rb_sel = 4'h0;
  reg  [1:0]  lat = 2'h0;
  wire [15:0] pm_addr, pm_wdata, pm_rdata, xd_addr, xd_wdata, xd_rdata;
  wire        pm_rd, pm_wr, pm_ack, xd_rd, xd_wr, xd_ack, busy, done, limit_flag;
  wire [35:0] rb_data;
  integer     failures = 0;
  integer     checked = 0;

  always #50 clock = ~clock;

  pmu_move_unit pmu_move_unit_i (.*);
  pmu_mem_model pmu_mem_model_i (.*);

  // -------------------------
  // helpers
  // -------------------------
  task complete_run;
    begin
      if (failures == 0 && checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  task chk(input [35:0] g, input [35:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // cycles from the taking edge to done: base + wait + one
  task issue(input [2:0] o, input [3:0] r, input [5:0] sa, input [15:0] im,
             input [1:0] l, input [4:0] base);
    integer n;
    begin
      @(negedge clock);
      op = o;
      reg_sel = r;
      short_addr = sa;
      imm = im;
      lat = l;
      start = 1'h1;
      @(negedge clock);
      start = 1'h0;
      n = 1;
      while (done !== 1'h1 && n < 40) begin
        @(negedge clock);
        n = n + 1;
      end
      chk(n, base + l + 2);
    end
  endtask

  task rb(input [3:0] r, input [35:0] e);
    begin
      rb_sel = r;
      @(negedge clock);
      chk(rb_data, e);
    end
  endtask

  // -------------------------
  // scenarios
  // -------------------------
  // never in data-execute mode
  task t_pm_read;
    begin
      pmu_mem_model_i.pmem[0] = 16'h8116;
      issue(`PMU_OP_PM_RD, `PMU_REG_A, 6'h0, 16'h0, 2'h0, 5'h8);
      rb(`PMU_REG_A, 36'hf81160000);
      rb(`PMU_REG_R0, 36'h1);
    end
  endtask

  task t_upper_step;
    begin
      pmu_mem_model_i.xmem[5] = 16'h0003;
      pmu_mem_model_i.pmem[1] = 16'h1234;
      issue(`PMU_OP_PP_RD, `PMU_REG_N, 6'h05, 16'h0, 2'h1, 5'h2);
      step_n = 1'h1;
      issue(`PMU_OP_PM_RD, `PMU_REG_A1, 6'h0, 16'h0, 2'h0, 5'h8);
      chk(pm_addr, 36'h1);
      rb(`PMU_REG_A, 36'hf12340000);
      rb(`PMU_REG_R0, 36'h4);
    end
  endtask

  // extension f with bit 31 clear must limit to the negative constant
  task t_limit;
    begin
      step_n = 1'h0;
      issue(`PMU_OP_PM_WR, `PMU_REG_A, 6'h0, 16'h0, 2'h0, 5'h8);
      chk(pmu_mem_model_i.pmem[4], 36'h8000);
      chk(limit_flag, 36'h1);
      rb(`PMU_REG_R0, 36'h5);
      issue(`PMU_OP_PP_WR, `PMU_REG_A1, 6'h3f, 16'h0, 2'h0, 5'h2);
      chk(pmu_mem_model_i.xmem[63], 36'h1234);
      chk(limit_flag, 36'h1);
      cond_code_wdata = 8'h00;
      cond_code_wr = 1'h1;
      @(negedge clock);
      cond_code_wr = 1'h0;
      @(negedge clock);
      chk(limit_flag, 36'h0);
    end
  endtask

  task t_pp_imm;
    begin
      issue(`PMU_OP_PP_IMM, 4'h0, 6'h24, 16'h0342, 2'h2, 5'h4);
      chk(xd_addr, 36'hffe4);
      chk(pmu_mem_model_i.xmem[36], 36'h0342);
      issue(`PMU_OP_PP_RD, `PMU_REG_B, 6'h24, 16'h0, 2'h1, 5'h2);
      rb(`PMU_REG_B, 36'h003420000);
    end
  endtask

  // extension 0 with bit 31 set must limit to the positive constant
  task t_limit_pos;
    begin
      pmu_mem_model_i.xmem[7] = 16'h8000;
      issue(`PMU_OP_PP_WR, `PMU_REG_B, 6'h10, 16'h0, 2'h0, 5'h2);
      chk(pmu_mem_model_i.xmem[16], 36'h0342);
      chk(limit_flag, 36'h0);
      issue(`PMU_OP_PP_RD, `PMU_REG_B1, 6'h07, 16'h0, 2'h0, 5'h2);
      rb(`PMU_REG_B, 36'h080000000);
      issue(`PMU_OP_PM_WR, `PMU_REG_B, 6'h0, 16'h0, 2'h1, 5'h8);
      chk(pmu_mem_model_i.pmem[5], 36'h7fff);
      chk(limit_flag, 36'h1);
    end
  endtask

  // reset between moves clears flag, registers and pointers
  task t_reset;
    begin
      srst = 1'h1;
      @(negedge clock);
      srst = 1'h0;
      chk(limit_flag, 36'h0);
      rb(`PMU_REG_B, 36'h0);
      issue(`PMU_OP_PM_RD, `PMU_REG_X0, 6'h0, 16'h0, 2'h0, 5'h8);
      rb(`PMU_REG_X0, 36'h8116);
    end
  endtask

  initial begin
    repeat (4) @(negedge clock);
    srst = 1'h0;
    t_pm_read;
    t_upper_step;
    t_limit;
    t_pp_imm;
    t_limit_pos;
    t_reset;
    complete_run;
  end

  initial begin
    #100000;
    failures = failures + 1;
    complete_run;
  end
endmodule // testbench
